// ### rtl/tmx_pkg.sv
package tmx_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] TMX_CTRL_ADDR  = 8'h88;
  localparam logic [7:0] TMX_MODE_ADDR  = 8'h89;
  localparam logic [7:0] TMX_T0LO_ADDR  = 8'h8A;
  localparam logic [7:0] TMX_T1LO_ADDR  = 8'h8B;
  localparam logic [7:0] TMX_T0HI_ADDR  = 8'h8C;
  localparam logic [7:0] TMX_T1HI_ADDR  = 8'h8D;
  localparam logic [7:0] TMX_RST_VAL    = 8'h00;

  // ----------------------------------------
  // Timer control register bits
  // ----------------------------------------
  localparam int TMX_TF1 = 7;
  localparam int TMX_TR1 = 6;
  localparam int TMX_TF0 = 5;
  localparam int TMX_TR0 = 4;
  localparam int TMX_IE1 = 3;
  localparam int TMX_IT1 = 2;
  localparam int TMX_IE0 = 1;
  localparam int TMX_IT0 = 0;

  // ----------------------------------------
  // Mode register bits
  // ----------------------------------------
  localparam int TMX_GATE1 = 7;
  localparam int TMX_CT1   = 6;
  localparam int TMX_M1_HI = 5;
  localparam int TMX_M1_LO = 4;
  localparam int TMX_GATE0 = 3;
  localparam int TMX_CT0   = 2;
  localparam int TMX_M0_HI = 1;
  localparam int TMX_M0_LO = 0;

  localparam logic [4:0] TMX_PRESCALE_MAX = 5'h1F;

  typedef enum logic [1:0] {
    TMX_MODE_13     = 2'b00,
    TMX_MODE_16     = 2'b01,
    TMX_MODE_RELOAD = 2'b10,
    TMX_MODE_SPLIT  = 2'b11
  } tmx_mode_e;

  function automatic logic tmx_fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

endpackage

// ### rtl/tmx_cnt_if.sv
interface tmx_cnt_if;
  import tmx_pkg::*;
  logic       inc_lo;
  logic       inc_hi;
  tmx_mode_e  mode;
  logic       wr_lo;
  logic       wr_hi;
  logic [7:0] wdata;
  logic [7:0] lo;
  logic [7:0] hi;
  logic       ovf_lo;
  logic       ovf_hi;

  modport ctl (output inc_lo, inc_hi, mode, wr_lo, wr_hi, wdata,
               input  lo, hi, ovf_lo, ovf_hi);
  modport cnt (input  inc_lo, inc_hi, mode, wr_lo, wr_hi, wdata,
               output lo, hi, ovf_lo, ovf_hi);
endinterface

// ### rtl/tmx_counter.sv
module tmx_counter (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  tmx_cnt_if.cnt    bus
);
  import tmx_pkg::*;

  logic [7:0] lo_reg;
  logic [7:0] hi_reg;
  logic [7:0] lo_next;
  logic [7:0] hi_next;

  // ----------------------------------------
  // Count step per mode
  // ----------------------------------------
  always_comb begin
    lo_next    = lo_reg;
    hi_next    = hi_reg;
    bus.ovf_lo = 1'b0;
    bus.ovf_hi = 1'b0;
    case (bus.mode)
      TMX_MODE_13: if (bus.inc_lo) begin
        // Upper three low-byte bits are left alone by the prescaler
        if (lo_reg[4:0] == TMX_PRESCALE_MAX) begin
          lo_next    = {lo_reg[7:5], 5'h00};
          hi_next    = hi_reg + 8'h01;
          bus.ovf_lo = &hi_reg;
        end else begin
          lo_next = {lo_reg[7:5], lo_reg[4:0] + 5'h01};
        end
      end
      TMX_MODE_16: if (bus.inc_lo) begin
        {hi_next, lo_next} = {hi_reg, lo_reg} + 16'h0001;
        bus.ovf_lo         = &{hi_reg, lo_reg};
      end
      TMX_MODE_RELOAD: if (bus.inc_lo) begin
        lo_next    = (&lo_reg) ? hi_reg : lo_reg + 8'h01;
        bus.ovf_lo = &lo_reg;
      end
      TMX_MODE_SPLIT: begin
        if (bus.inc_lo) begin
          lo_next    = lo_reg + 8'h01;
          bus.ovf_lo = &lo_reg;
        end
        if (bus.inc_hi) begin
          hi_next    = hi_reg + 8'h01;
          bus.ovf_hi = &hi_reg;
        end
      end
      default: ;
    endcase
    // Software write beats a count in the same cycle
    if (bus.wr_lo) begin
      lo_next = bus.wdata;
    end
    if (bus.wr_hi) begin
      hi_next = bus.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lo_reg <= TMX_RST_VAL;
      hi_reg <= TMX_RST_VAL;
    end else begin
      lo_reg <= lo_next;
      hi_reg <= hi_next;
    end
  end

  assign bus.lo = lo_reg;
  assign bus.hi = hi_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  reload_from_hi_a: assert property (
    bus.mode == TMX_MODE_RELOAD && bus.inc_lo && lo_reg == 8'hFF && !bus.wr_lo
    |=> lo_reg == $past(hi_reg))
    else $error("Reload did not copy high byte");
  split_hi_step_a: assert property (
    bus.mode == TMX_MODE_SPLIT && bus.inc_hi && !bus.wr_hi
    |=> hi_reg == $past(hi_reg) + 8'h01)
    else $error("Split high byte did not step");
  presc_carry_a: assert property (
    bus.mode == TMX_MODE_13 && bus.inc_lo && lo_reg[4:0] == TMX_PRESCALE_MAX && !bus.wr_hi && !bus.wr_lo
    |=> hi_reg == $past(hi_reg) + 8'h01 && lo_reg[4:0] == 5'h00)
    else $error("Prescaler carry lost");
  reload_seen_c: cover property (bus.mode == TMX_MODE_RELOAD && bus.ovf_lo);
endmodule

// ### rtl/tmx_ext_detect.sv
module tmx_ext_detect (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic pin,
  input  wire logic type_sel,
  input  wire logic vec_ack,
  input  wire logic sw_wr,
  input  wire logic sw_val,
  output logic      flag
);
  import tmx_pkg::*;

  logic prev_reg;
  logic flag_reg;
  logic fall;

  assign fall = tmx_fall(prev_reg, pin);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= pin;
    end
  end

  // ----------------------------------------
  // Detect flag
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= 1'b0;
    end else if (!type_sel) begin
      flag_reg <= ~pin;
    end else if (fall) begin
      flag_reg <= 1'b1;
    end else if (sw_wr) begin
      flag_reg <= sw_val;
    end else if (vec_ack) begin
      flag_reg <= 1'b0;
    end
  end

  assign flag = flag_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  level_follow_a: assert property (!type_sel |=> flag_reg == !$past(pin))
    else $error("Level flag not inverse of pin");
  edge_set_a: assert property (type_sel && fall |=> flag_reg)
    else $error("Falling edge not flagged");
  ack_clear_a: assert property (type_sel && vec_ack && !fall && !sw_wr |=> !flag_reg)
    else $error("Vector ack did not clear edge flag");
  edge_hit_c: cover property (type_sel && fall);
endmodule

// ### rtl/tmx_timers.sv
// Decided for this implementation: the register addresses and the plain strobed port.
module tmx_timers (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rd_data,
  input  wire logic        ext_irq_pin_0,
  input  wire logic        ext_irq_pin_1,
  input  wire logic        count_pin_0,
  input  wire logic        count_pin_1,
  input  wire logic        irq0_vector_ack,
  input  wire logic        irq1_vector_ack,
  output logic             ext_irq0_detect_flag,
  output logic             ext_irq1_detect_flag,
  output logic             timer0_ovf_flag,
  output logic             timer1_ovf_flag
);
  import tmx_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] timer_mode_config_reg;
  logic       timer0_run_reg;
  logic       timer1_run_reg;
  logic       ext_irq0_type_sel_reg;
  logic       ext_irq1_type_sel_reg;
  logic       tf0_reg;
  logic       tf1_reg;
  logic [7:0] rd_data_reg;
  logic       cnt0_prev_reg;
  logic       cnt1_prev_reg;

  logic       ctrl_wr;
  logic       mode_wr;
  logic       en0;
  logic       en1;
  logic       tick0;
  logic       tick1;
  logic       ie0_flag;
  logic       ie1_flag;
  tmx_mode_e  mode0;
  tmx_mode_e  mode1;
  logic [7:0] ctrl_view;

  tmx_cnt_if t0_if ();
  tmx_cnt_if t1_if ();

  assign ctrl_wr = wr_en && addr == TMX_CTRL_ADDR;
  assign mode_wr = wr_en && addr == TMX_MODE_ADDR;

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      timer_mode_config_reg <= TMX_RST_VAL;
    end else if (mode_wr) begin
      timer_mode_config_reg <= wr_data;
    end
  end

  // Mode fields split out of the register
  assign mode0 = tmx_mode_e'({timer_mode_config_reg[TMX_M0_HI],
                              timer_mode_config_reg[TMX_M0_LO]});
  assign mode1 = tmx_mode_e'({timer_mode_config_reg[TMX_M1_HI],
                              timer_mode_config_reg[TMX_M1_LO]});

  // ----------------------------------------
  // Run and type control bits
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      timer0_run_reg        <= 1'b0;
      timer1_run_reg        <= 1'b0;
      ext_irq0_type_sel_reg <= 1'b0;
      ext_irq1_type_sel_reg <= 1'b0;
    end else if (ctrl_wr) begin
      timer0_run_reg        <= wr_data[TMX_TR0];
      timer1_run_reg        <= wr_data[TMX_TR1];
      ext_irq0_type_sel_reg <= wr_data[TMX_IT0];
      ext_irq1_type_sel_reg <= wr_data[TMX_IT1];
    end
  end

  // ----------------------------------------
  // Count pin edge detection
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt0_prev_reg <= 1'b1;
      cnt1_prev_reg <= 1'b1;
    end else begin
      cnt0_prev_reg <= count_pin_0;
      cnt1_prev_reg <= count_pin_1;
    end
  end

  // ----------------------------------------
  // Gating and source select
  // ----------------------------------------
  // Internal clock source advances once per system clock
  assign en0 = timer0_run_reg &&
               (!timer_mode_config_reg[TMX_GATE0] || ext_irq_pin_0);
  assign en1 = timer1_run_reg &&
               (!timer_mode_config_reg[TMX_GATE1] || ext_irq_pin_1);
  assign tick0 = en0 && (timer_mode_config_reg[TMX_CT0] ?
                         tmx_fall(cnt0_prev_reg, count_pin_0) : 1'b1);
  assign tick1 = en1 && (timer_mode_config_reg[TMX_CT1] ?
                         tmx_fall(cnt1_prev_reg, count_pin_1) : 1'b1);

  // ----------------------------------------
  // Counter control
  // ----------------------------------------
  assign t0_if.mode   = mode0;
  assign t0_if.inc_lo = tick0;
  // Borrowed high byte only uses the run bit, never gate or pin
  assign t0_if.inc_hi = mode0 == TMX_MODE_SPLIT && timer1_run_reg;
  assign t0_if.wr_lo  = wr_en && addr == TMX_T0LO_ADDR;
  assign t0_if.wr_hi  = wr_en && addr == TMX_T0HI_ADDR;
  assign t0_if.wdata  = wr_data;

  assign t1_if.mode   = mode1;
  assign t1_if.inc_lo = tick1 && mode1 != TMX_MODE_SPLIT;
  assign t1_if.inc_hi = 1'b0;
  assign t1_if.wr_lo  = wr_en && addr == TMX_T1LO_ADDR;
  assign t1_if.wr_hi  = wr_en && addr == TMX_T1HI_ADDR;
  assign t1_if.wdata  = wr_data;

  tmx_counter u_timer0 (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .bus     (t0_if.cnt)
  );

  tmx_counter u_timer1 (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .bus     (t1_if.cnt)
  );

  // ----------------------------------------
  // Overflow flags
  // ----------------------------------------
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tf0_reg <= 1'b0;
    end else if (t0_if.ovf_lo) begin
      tf0_reg <= 1'b1;
    end else if (ctrl_wr) begin
      tf0_reg <= wr_data[TMX_TF0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tf1_reg <= 1'b0;
    end else if (t1_if.ovf_lo || t0_if.ovf_hi) begin
      tf1_reg <= 1'b1;
    end else if (ctrl_wr) begin
      tf1_reg <= wr_data[TMX_TF1];
    end
  end

  // ----------------------------------------
  // External pin detectors
  // ----------------------------------------
  tmx_ext_detect u_ext0 (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pin      (ext_irq_pin_0),
    .type_sel (ext_irq0_type_sel_reg),
    .vec_ack  (irq0_vector_ack),
    .sw_wr    (ctrl_wr),
    .sw_val   (wr_data[TMX_IE0]),
    .flag     (ie0_flag)
  );

  tmx_ext_detect u_ext1 (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pin      (ext_irq_pin_1),
    .type_sel (ext_irq1_type_sel_reg),
    .vec_ack  (irq1_vector_ack),
    .sw_wr    (ctrl_wr),
    .sw_val   (wr_data[TMX_IE1]),
    .flag     (ie1_flag)
  );

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    ctrl_view          = TMX_RST_VAL;
    ctrl_view[TMX_TF1] = tf1_reg;
    ctrl_view[TMX_TR1] = timer1_run_reg;
    ctrl_view[TMX_TF0] = tf0_reg;
    ctrl_view[TMX_TR0] = timer0_run_reg;
    ctrl_view[TMX_IE1] = ie1_flag;
    ctrl_view[TMX_IT1] = ext_irq1_type_sel_reg;
    ctrl_view[TMX_IE0] = ie0_flag;
    ctrl_view[TMX_IT0] = ext_irq0_type_sel_reg;
  end

  // Data valid only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= TMX_RST_VAL;
    end else if (rd_en) begin
      case (addr)
        TMX_CTRL_ADDR: rd_data_reg <= ctrl_view;
        TMX_MODE_ADDR: rd_data_reg <= timer_mode_config_reg;
        TMX_T0LO_ADDR: rd_data_reg <= t0_if.lo;
        TMX_T1LO_ADDR: rd_data_reg <= t1_if.lo;
        TMX_T0HI_ADDR: rd_data_reg <= t0_if.hi;
        TMX_T1HI_ADDR: rd_data_reg <= t1_if.hi;
        default:       rd_data_reg <= TMX_RST_VAL;
      endcase
    end else begin
      rd_data_reg <= TMX_RST_VAL;
    end
  end

  assign rd_data              = rd_data_reg;
  assign ext_irq0_detect_flag = ie0_flag;
  assign ext_irq1_detect_flag = ie1_flag;
  assign timer0_ovf_flag      = tf0_reg;
  assign timer1_ovf_flag      = tf1_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  run_stops_t0_a: assert property (
    !timer0_run_reg && !t0_if.wr_lo && !t0_if.wr_hi && mode0 != TMX_MODE_SPLIT
    |=> t0_if.lo == $past(t0_if.lo) && t0_if.hi == $past(t0_if.hi))
    else $error("Timer 0 moved while stopped");
  gate_t0_a: assert property (
    timer_mode_config_reg[TMX_GATE0] && !ext_irq_pin_0 |-> !t0_if.inc_lo)
    else $error("Timer 0 counted with gate pin low");
  gate_t1_a: assert property (
    timer_mode_config_reg[TMX_GATE1] && !ext_irq_pin_1 |-> !t1_if.inc_lo)
    else $error("Timer 1 counted with gate pin low");
  ungated_run_a: assert property (
    !timer_mode_config_reg[TMX_GATE0] && timer0_run_reg &&
    !timer_mode_config_reg[TMX_CT0] |-> t0_if.inc_lo)
    else $error("Ungated timer 0 did not count");
  pin_source_a: assert property (
    timer_mode_config_reg[TMX_CT1] && t1_if.inc_lo
    |-> $past(count_pin_1) && !count_pin_1)
    else $error("Timer 1 counted without a pin fall");
  pin_source0_a: assert property (
    timer_mode_config_reg[TMX_CT0] && t0_if.inc_lo
    |-> $past(count_pin_0) && !count_pin_0)
    else $error("Timer 0 counted without a pin fall");
  t1_split_hold_a: assert property (
    mode1 == TMX_MODE_SPLIT && !t1_if.wr_lo && !t1_if.wr_hi
    |=> t1_if.lo == $past(t1_if.lo) && t1_if.hi == $past(t1_if.hi))
    else $error("Timer 1 moved in mode 11");
  split_borrow_a: assert property (
    mode0 == TMX_MODE_SPLIT && timer1_run_reg |-> t0_if.inc_hi)
    else $error("Borrowed byte ignored timer 1 run");
  ovf_sets_tf_a: assert property (
    t0_if.ovf_lo |=> tf0_reg)
    else $error("Timer 0 overflow flag not set");
  // A software clear in the wrap cycle loses, so the flag must still rise
  t1_ovf_sets_a: assert property (
    t1_if.ovf_lo |=> tf1_reg)
    else $error("Timer 1 overflow flag not set");
  split_flag_a: assert property (
    t0_if.ovf_hi |=> tf1_reg)
    else $error("Borrowed byte wrap did not set timer 1 flag");
  mode_fields_a: assert property (
    mode_wr |=> {mode1, mode0} == {$past(wr_data[TMX_M1_HI:TMX_M1_LO]), $past(wr_data[TMX_M0_HI:TMX_M0_LO])})
    else $error("Mode field not taken from its bits");
  ungated_run1_a: assert property (
    !timer_mode_config_reg[TMX_GATE1] && timer1_run_reg && !timer_mode_config_reg[TMX_CT1] &&
    mode1 != TMX_MODE_SPLIT |-> t1_if.inc_lo)
    else $error("Ungated timer 1 did not count");
  split_lo_ctl_a: assert property (
    mode0 == TMX_MODE_SPLIT && !timer0_run_reg |-> !t0_if.inc_lo)
    else $error("Split low byte ignored timer 0 run");

  t0_wrap_c: cover property (t0_if.ovf_lo);
  split_run_c: cover property (mode0 == TMX_MODE_SPLIT && t0_if.inc_lo && t0_if.inc_hi);
  gated_c: cover property (timer_mode_config_reg[TMX_GATE0] && timer0_run_reg ##1 !ext_irq_pin_0);
endmodule

// ### verification/tmx_pin_model.sv
module tmx_pin_model (
  input  wire logic clk_sys,
  output logic      ext_irq_pin_0,
  output logic      ext_irq_pin_1,
  output logic      count_pin_0,
  output logic      count_pin_1
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  // Port pins sit behind pull-ups, so every pin idles high
  logic [1:0] irq_lvl = 2'b11;
  logic [1:0] cnt_lvl = 2'b11;

  assign ext_irq_pin_0 = irq_lvl[0];
  assign ext_irq_pin_1 = irq_lvl[1];
  assign count_pin_0   = cnt_lvl[0];
  assign count_pin_1   = cnt_lvl[1];

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic set_irq(input int idx, input logic val);
    @(posedge clk_sys);
    irq_lvl[idx] <= val;
  endtask

  // Hold sets both pulse phases, so one task gives fast and slow edges
  task automatic pulse(input int idx, input int n, input int hold);
    repeat (n) begin
      @(posedge clk_sys);
      cnt_lvl[idx] <= 1'b0;
      repeat (hold) @(posedge clk_sys);
      cnt_lvl[idx] <= 1'b1;
      repeat (hold - 1) @(posedge clk_sys);
    end
  endtask
endmodule

// ### verification/tmx_timers_test.sv
module tmx_timers_test;
  timeunit 1ns;
  timeprecision 1ns;
  import tmx_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct {
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic       p0;
    logic       p1;
    logic [7:0] lo_a;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] ex_lo;
    logic [7:0] ex_hi;
  } tmx_row_s;

  logic       clk_sys = 1'b0;
  logic       rst_b   = 1'b0;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic       wr_en   = 1'b0;
  logic       rd_en   = 1'b0;
  logic [1:0] ack     = 2'b00;
  logic [7:0] rd_data;
  logic [1:0] flag;
  logic [1:0] ovf;
  wire logic  pin0;
  wire logic  pin1;
  wire logic  cp0;
  wire logic  cp1;
  int         fails = 0;
  int         checks_done = 0;

  // Each row runs five clocks: start write edge to stop write edge
  tmx_row_s rows [13] = '{
    '{8'h01, 8'h10, 1'b1, 1'b1, 8'h8A, 8'h12, 8'hFE, 8'h03, 8'h13},
    '{8'h00, 8'h10, 1'b1, 1'b1, 8'h8A, 8'h40, 8'hFD, 8'hE2, 8'h41},
    '{8'h02, 8'h10, 1'b1, 1'b1, 8'h8A, 8'hF0, 8'hFD, 8'hF2, 8'hF0},
    '{8'h03, 8'h10, 1'b1, 1'b1, 8'h8A, 8'h33, 8'h10, 8'h15, 8'h33},
    '{8'h01, 8'h00, 1'b1, 1'b1, 8'h8A, 8'h01, 8'h02, 8'h02, 8'h01},
    '{8'h09, 8'h10, 1'b0, 1'b1, 8'h8A, 8'h00, 8'h20, 8'h20, 8'h00},
    '{8'h09, 8'h10, 1'b1, 1'b1, 8'h8A, 8'h00, 8'h20, 8'h25, 8'h00},
    '{8'h01, 8'h10, 1'b0, 1'b1, 8'h8A, 8'h00, 8'h20, 8'h25, 8'h00},
    '{8'h90, 8'h40, 1'b1, 1'b0, 8'h8B, 8'h00, 8'h40, 8'h40, 8'h00},
    '{8'h90, 8'h40, 1'b1, 1'b1, 8'h8B, 8'h00, 8'h40, 8'h45, 8'h00},
    '{8'h30, 8'h40, 1'b1, 1'b1, 8'h8B, 8'h00, 8'h40, 8'h40, 8'h00},
    '{8'h03, 8'h40, 1'b1, 1'b1, 8'h8A, 8'h20, 8'h10, 8'h10, 8'h25},
    '{8'h10, 8'h40, 1'b1, 1'b1, 8'h8B, 8'h00, 8'h07, 8'h0C, 8'h00}
  };

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  tmx_timers dut (
    .clk_sys              (clk_sys),
    .rst_b                (rst_b),
    .addr                 (addr),
    .wr_data              (wr_data),
    .wr_en                (wr_en),
    .rd_en                (rd_en),
    .rd_data              (rd_data),
    .ext_irq_pin_0        (pin0),
    .ext_irq_pin_1        (pin1),
    .count_pin_0          (cp0),
    .count_pin_1          (cp1),
    .irq0_vector_ack      (ack[0]),
    .irq1_vector_ack      (ack[1]),
    .ext_irq0_detect_flag (flag[0]),
    .ext_irq1_detect_flag (flag[1]),
    .timer0_ovf_flag      (ovf[0]),
    .timer1_ovf_flag      (ovf[1])
  );

  tmx_pin_model u_pins (
    .clk_sys       (clk_sys),
    .ext_irq_pin_0 (pin0),
    .ext_irq_pin_1 (pin1),
    .count_pin_0   (cp0),
    .count_pin_1   (cp1)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Strobe drops on the taking edge, so back-to-back calls leave one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp, what);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      u_pins.set_irq(0, rows[i].p0);
      u_pins.set_irq(1, rows[i].p1);
      wr(TMX_MODE_ADDR, rows[i].mode);
      wr(rows[i].lo_a, rows[i].lo);
      wr(rows[i].lo_a + 8'h02, rows[i].hi);
      wr(TMX_CTRL_ADDR, rows[i].ctrl);
      repeat (3) @(posedge clk_sys);
      wr(TMX_CTRL_ADDR, 8'h00);
      rd(rows[i].lo_a, rows[i].ex_lo, "row low byte");
      rd(rows[i].lo_a + 8'h02, rows[i].ex_hi, "row high byte");
    end

    // Pin sources: fast edges on one pin, slow edges on the other
    wr(TMX_MODE_ADDR, 8'h55);
    wr(TMX_T0LO_ADDR, 8'h00);
    wr(TMX_T1LO_ADDR, 8'h00);
    wr(TMX_CTRL_ADDR, 8'h50);
    fork
      u_pins.pulse(0, 3, 1);
      u_pins.pulse(1, 2, 3);
    join
    repeat (2) @(posedge clk_sys);
    wr(TMX_CTRL_ADDR, 8'h00);
    rd(TMX_T0LO_ADDR, 8'h03, "pin source timer 0");
    rd(TMX_T1LO_ADDR, 8'h02, "pin source timer 1");

    // Detect flags: edge mode latches and clears on ack, level mode follows pin
    for (int i = 0; i < 2; i++) begin
      wr(TMX_CTRL_ADDR, (i == 1) ? 8'h04 : 8'h01);
      u_pins.set_irq(i, 1'b0);
      repeat (2) @(posedge clk_sys);
      #1;
      chk({7'h00, flag[i]}, 8'h01, "edge flag set");
      rd(TMX_CTRL_ADDR, (i == 1) ? 8'h0C : 8'h03, "flag bit in control");
      u_pins.set_irq(i, 1'b1);
      repeat (2) @(posedge clk_sys);
      #1;
      chk({7'h00, flag[i]}, 8'h01, "edge flag held with pin high");
      @(posedge clk_sys);
      ack[i] <= 1'b1;
      @(posedge clk_sys);
      ack[i] <= 1'b0;
      #1;
      chk({7'h00, flag[i]}, 8'h00, "edge flag cleared by ack");
      wr(TMX_CTRL_ADDR, 8'h00);
      u_pins.set_irq(i, 1'b0);
      repeat (2) @(posedge clk_sys);
      ack[i] <= 1'b1;
      @(posedge clk_sys);
      ack[i] <= 1'b0;
      #1;
      chk({7'h00, flag[i]}, 8'h01, "level flag ignores ack");
      u_pins.set_irq(i, 1'b1);
      repeat (2) @(posedge clk_sys);
      #1;
      chk({7'h00, flag[i]}, 8'h00, "level flag follows pin");
    end

    // Overflow flags: timer 0 wraps and the borrowed high byte sets the timer 1 flag
    wr(TMX_MODE_ADDR, 8'h03);
    wr(TMX_T0LO_ADDR, 8'hFF);
    wr(TMX_T0HI_ADDR, 8'hFF);
    wr(TMX_CTRL_ADDR, 8'h50);
    @(posedge clk_sys);
    #1;
    chk({6'h00, ovf}, 8'h03, "overflow flags set");
    wr(TMX_CTRL_ADDR, 8'h00);
    #1;
    chk({6'h00, ovf}, 8'h00, "overflow flags cleared by write");

    // Register map, unmapped place, read data lasting one cycle
    wr(TMX_MODE_ADDR, 8'hA5);
    rd(TMX_MODE_ADDR, 8'hA5, "mode readback");
    @(posedge clk_sys);
    #1;
    chk(rd_data, 8'h00, "read data after its cycle");
    wr(8'h90, 8'h5A);
    rd(8'h90, 8'h00, "unmapped read");

    // Reset in mid-run returns every register to zero
    wr(TMX_CTRL_ADDR, 8'h50);
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    chk({4'h0, flag, ovf}, 8'h00, "outputs after reset");
    for (int a = 0; a < 6; a++) begin
      rd(TMX_CTRL_ADDR + a[7:0], TMX_RST_VAL, "reset value");
    end
    stop_test();
  end
endmodule
